/* File: hdl/cmv_maint_view.sv */
// Channel maintenance view registers behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "cmv_regs.svh"

// ****************************************************************
// ****************************************************************

module cmv_maint_view
  import cmv_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Channel cable lines, asynchronous pins
  input  wire cmv_out_word_t       cable_out_lines,
  // Inbound lines driven by the interface logic
  input  wire cmv_in_ctl_t         inbound_lines,
  input  wire logic [7:0]          inbound_enabled_data,
  // Sequencer state, same clock
  input  wire logic                online,
  input  wire logic [2:0]          major_phase,
  input  wire logic                time_state_flop,
  // Lockout towards the programmable registers
  output logic                     register_write_lockout
);

  // ****************************************************************
  // Declarations
  // ****************************************************************

  cmv_out_word_t   out_sync1;
  cmv_out_word_t   out_sync2;
  cmv_out_word_t   maint_out_lines;
  cmv_in_word_t    maint_in_lines;
  logic [7:0]      offline_outbound_buffer;
  logic [2:0]      phase_seen;
  logic            time_state_seen;
  logic [15:0]     control_bits;

  logic            aw_held;
  logic            w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            do_write;
  cmv_sel_t        wr_sel;
  cmv_sel_t        rd_sel;
  logic [31:0]     next_rdata;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Address to register select
  function automatic cmv_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    if (a[1:0] != 2'h0) begin
      decode = CMV_SEL_NONE;
    end else if (a == `CMV_OFF_MAINT_OUT) begin
      decode = CMV_SEL_OUT;
    end else if (a == `CMV_OFF_MAINT_IN) begin
      decode = CMV_SEL_IN;
    end else if (a == `CMV_OFF_CONTROL) begin
      decode = CMV_SEL_CTL;
    end else begin
      decode = CMV_SEL_NONE;
    end
  endfunction

  // Word padded from a 16-bit register
  function automatic logic [31:0] widen(input logic [15:0] v);
    widen = {16'h0000, v};
  endfunction

  // ****************************************************************
  // Line sampling
  // ****************************************************************

  // Two-flop synchroniser for the cable lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_sync1 <= `CMV_RST_WORD;
      out_sync2 <= `CMV_RST_WORD;
    end else if (ce) begin
      out_sync1 <= cable_out_lines;
      out_sync2 <= out_sync1;
    end
  end

  // Outbound mirror, sampled once a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      maint_out_lines <= `CMV_RST_WORD;
    end else if (ce) begin
      maint_out_lines.outbound_control_byte <=
        out_sync2.outbound_control_byte;
      if (online) begin
        maint_out_lines.outbound_data_byte <=
          out_sync2.outbound_data_byte;
      end else begin
        maint_out_lines.outbound_data_byte <=
          offline_outbound_buffer;
      end
    end
  end

  // Inbound mirror, sampled once a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      maint_in_lines <= `CMV_RST_WORD;
    end else if (ce) begin
      maint_in_lines.inbound_control_byte <= inbound_lines;
      maint_in_lines.inbound_data_byte    <= inbound_enabled_data;
    end
  end

  // Phase and time state capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_seen <= `CMV_RST_PHASE;
      time_state_seen <= 1'b0;
    end else if (ce) begin
      phase_seen <= major_phase;
      time_state_seen <= time_state_flop;
    end
  end

  // Control bits word as read
  always_comb begin
    control_bits = `CMV_RST_WORD;
    control_bits[`CMV_CB_LOCKOUT] = register_write_lockout;
    control_bits[`CMV_CB_TIME_STATE] = time_state_seen;
    control_bits[`CMV_CB_PHASE_MSB:`CMV_CB_PHASE_LSB] = phase_seen;
  end

  // ****************************************************************
  // Write channel
  // ****************************************************************

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel   = decode(aw_addr);

  // Address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b1;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= `CMV_RST_DATA;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CMV_RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == CMV_SEL_NONE) ?
                        `CMV_RESP_DECERR : `CMV_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Offline buffer, written through the low data lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offline_outbound_buffer <= `CMV_RST_BYTE;
    end else if (ce) begin
      if (do_write && wr_sel == CMV_SEL_OUT && w_strb[`CMV_LANE_LOW]) begin
        offline_outbound_buffer <= w_data[7:0];
      end
    end
  end

  // Lockout flag, written through the high data lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      register_write_lockout <= 1'b0;
    end else if (ce) begin
      if (do_write && wr_sel == CMV_SEL_CTL && w_strb[`CMV_LANE_HIGH]) begin
        register_write_lockout <= w_data[`CMV_CB_LOCKOUT];
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************

  assign rd_sel = decode(s_axi_araddr);

  // Read data selection
  always_comb begin
    next_rdata = `CMV_RST_DATA;
    unique case (rd_sel)
      CMV_SEL_OUT: begin
        next_rdata = widen(maint_out_lines);
      end
      CMV_SEL_IN: begin
        next_rdata = widen(maint_in_lines);
      end
      CMV_SEL_CTL: begin
        next_rdata = widen(control_bits);
      end
      CMV_SEL_NONE: begin
        next_rdata = `CMV_RST_DATA;
      end
    endcase
  end

  // Read address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `CMV_RST_DATA;
      s_axi_rresp   <= `CMV_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= (rd_sel == CMV_SEL_NONE) ?
                         `CMV_RESP_DECERR : `CMV_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: shared/cmv_pkg.sv */
// Types shared by the channel maintenance view registers
package cmv_pkg;

  // Outbound control lines, upper byte of maint_out_lines
  typedef struct packed {
    logic operational_out;
    logic hold_out;
    logic select_out;
    logic suppress_out;
    logic address_out;
    logic command_out;
    logic service_out;
    logic outbound_parity;
  } cmv_out_ctl_t;

  // Inbound control lines, upper byte of maint_in_lines
  typedef struct packed {
    logic operational_in;
    logic select_in;
    logic request_in;
    logic address_in;
    logic status_in;
    logic service_in;
    logic clock_out_line;
    logic inbound_parity;
  } cmv_in_ctl_t;

  // Outbound register word
  typedef struct packed {
    cmv_out_ctl_t outbound_control_byte;
    logic [7:0]   outbound_data_byte;
  } cmv_out_word_t;

  // Inbound register word
  typedef struct packed {
    cmv_in_ctl_t  inbound_control_byte;
    logic [7:0]   inbound_data_byte;
  } cmv_in_word_t;

  // Register selected by an address
  typedef enum logic [1:0] {
    CMV_SEL_NONE,
    CMV_SEL_OUT,
    CMV_SEL_IN,
    CMV_SEL_CTL
  } cmv_sel_t;

endpackage

/* File: shared/cmv_regs.svh */
// Register offsets, field positions and reset values of the maintenance view
`ifndef CMV_REGS_SVH
`define CMV_REGS_SVH

// Byte offsets of the three registers
`define CMV_OFF_MAINT_OUT   8'h00
`define CMV_OFF_MAINT_IN    8'h04
`define CMV_OFF_CONTROL     8'h08

// Address bits that are decoded
`define CMV_ADDR_MSB        7
`define CMV_ADDR_LSB        2

// Field positions inside control_bits
`define CMV_CB_LOCKOUT      15
`define CMV_CB_TIME_STATE   3
`define CMV_CB_PHASE_MSB    2
`define CMV_CB_PHASE_LSB    0

// Byte lanes
`define CMV_LANE_LOW        0
`define CMV_LANE_HIGH       1

// Reset values
`define CMV_RST_WORD        16'h0000
`define CMV_RST_BYTE        8'h00
`define CMV_RST_PHASE       3'h0
`define CMV_RST_DATA        32'h0000_0000

// Response codes
`define CMV_RESP_OKAY       2'h0
`define CMV_RESP_DECERR     2'h3

`endif

/* File: tb/cmv_chan_model.sv */
// Channel side model driving the outbound cable lines
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Outbound cable driver
// ****************************************************************
module cmv_chan_model
  import cmv_pkg::*;
(
  input  wire logic     aclk,
  output var cmv_out_word_t cable_out_lines
);
  // Lines idle low until the first frame
  initial cable_out_lines = '0;
  // New line state right after an edge
  task automatic drive(input cmv_out_word_t v);
    @(posedge aclk);
    cable_out_lines <= v;
  endtask
endmodule
`default_nettype wire

/* File: tb/cmv_maint_view_properties.sv */
// Checker for the register bus and the mirrored inbound lines
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Checker
// ****************************************************************
module cmv_maint_view_properties
  import cmv_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire cmv_in_ctl_t       inbound_lines,
  input wire logic [7:0]        inbound_enabled_data,
  input wire logic [2:0]        major_phase,
  input wire logic              time_state_flop,
  input wire logic              register_write_lockout
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ar;
  // Read address taken with the clock enabled
  assign ar = ce && s_axi_arvalid && s_axi_arready;
  a_r_latency: assert property (ar |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer moved");
  a_b_latency: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready ##1 ce |-> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  a_in_mirror: assert property (
    ar && $past(ce) && $past(aresetn) && s_axi_araddr == 8'h04 |=>
    s_axi_rdata == {16'h0, $past({inbound_lines, inbound_enabled_data}, 2)})
    else $error("inbound mirror wrong");
  a_ctl_fields: assert property (
    ar && $past(ce) && $past(aresetn) && s_axi_araddr == 8'h08 |=>
    s_axi_rdata[14:0] == {11'h0, $past({time_state_flop, major_phase}, 2)})
    else $error("control fields wrong");
  a_lock_read: assert property (
    ar && s_axi_araddr == 8'h08 |=>
    s_axi_rdata[15] == $past(register_write_lockout)) else $error("lockout read wrong");
  a_decode_err: assert property (ar && (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > 8'h08) |=>
    s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("bad address answered");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper half not zero");
  c_ctl_read: cover property (ar && s_axi_araddr == 8'h08);
  c_lock_set: cover property ($rose(register_write_lockout));
  c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule
bind cmv_maint_view cmv_maint_view_properties #(.ADDR_W(ADDR_W)) u_props (
  .aclk                   (aclk),
  .aresetn                (aresetn),
  .ce                     (ce),
  .s_axi_awvalid          (s_axi_awvalid),
  .s_axi_awready          (s_axi_awready),
  .s_axi_wvalid           (s_axi_wvalid),
  .s_axi_wready           (s_axi_wready),
  .s_axi_bresp            (s_axi_bresp),
  .s_axi_bvalid           (s_axi_bvalid),
  .s_axi_bready           (s_axi_bready),
  .s_axi_araddr           (s_axi_araddr),
  .s_axi_arvalid          (s_axi_arvalid),
  .s_axi_arready          (s_axi_arready),
  .s_axi_rdata            (s_axi_rdata),
  .s_axi_rresp            (s_axi_rresp),
  .s_axi_rvalid           (s_axi_rvalid),
  .s_axi_rready           (s_axi_rready),
  .inbound_lines          (inbound_lines),
  .inbound_enabled_data   (inbound_enabled_data),
  .major_phase            (major_phase),
  .time_state_flop        (time_state_flop),
  .register_write_lockout (register_write_lockout)
);
`default_nettype wire

/* File: tb/cmv_maint_view_tb_top.sv */
// Testbench for the channel maintenance view registers
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Bench
// ****************************************************************
module cmv_maint_view_tb_top;
  import cmv_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, online = 0, time_state_flop = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, inbound_enabled_data = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, major_phase = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, register_write_lockout;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  cmv_in_ctl_t inbound_lines = '0;
  cmv_out_word_t cable_out_lines, cw;
  int miscompares = 0, num_checks = 0;
  logic [7:0] bad [3] = '{8'h0C, 8'h02, 8'hFC};

  cmv_maint_view u_cmv_maint_view (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .ce                     (ce),
    .s_axi_awaddr           (s_axi_awaddr),
    .s_axi_awprot           (s_axi_awprot),
    .s_axi_awvalid          (s_axi_awvalid),
    .s_axi_awready          (s_axi_awready),
    .s_axi_wdata            (s_axi_wdata),
    .s_axi_wstrb            (s_axi_wstrb),
    .s_axi_wvalid           (s_axi_wvalid),
    .s_axi_wready           (s_axi_wready),
    .s_axi_bresp            (s_axi_bresp),
    .s_axi_bvalid           (s_axi_bvalid),
    .s_axi_bready           (s_axi_bready),
    .s_axi_araddr           (s_axi_araddr),
    .s_axi_arprot           (s_axi_arprot),
    .s_axi_arvalid          (s_axi_arvalid),
    .s_axi_arready          (s_axi_arready),
    .s_axi_rdata            (s_axi_rdata),
    .s_axi_rresp            (s_axi_rresp),
    .s_axi_rvalid           (s_axi_rvalid),
    .s_axi_rready           (s_axi_rready),
    .cable_out_lines        (cable_out_lines),
    .inbound_lines          (inbound_lines),
    .inbound_enabled_data   (inbound_enabled_data),
    .online                 (online),
    .major_phase            (major_phase),
    .time_state_flop        (time_state_flop),
    .register_write_lockout (register_write_lockout)
  );
  cmv_chan_model u_cmv_chan_model (.aclk(aclk), .cable_out_lines(cable_out_lines));

  // Clock, 8 ns period
  always #4 aclk = ~aclk;

  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Write with address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Idle edge, so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    // Idle edge, so a following call never reassigns rready in this step
    @(posedge aclk);
  endtask

  // Hang guard
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h08, d, r);
    chk(d, 32'h0);
    for (int i = 0; i < 8; i++) begin
      cw = {8'h01 << i, 8'h80 >> i};
      u_cmv_chan_model.drive(cw);
      online <= 1'b1;
      inbound_lines <= 8'h80 >> i;
      inbound_enabled_data <= 8'h01 << i;
      major_phase <= i[2:0];
      time_state_flop <= i[0];
      repeat (4) @(posedge aclk);
      rd(8'h00, d, r);
      chk(d, {16'h0, cw});
      rd(8'h04, d, r);
      chk(d, {16'h0, 8'h80 >> i, 8'h01 << i});
      rd(8'h08, d, r);
      chk(d, {28'h0, i[0], i[2:0]});
    end
    online <= 1'b0;
    wr(8'h00, 32'h0000_FF3C, 4'h3, r);
    rd(8'h00, d, r);
    chk(d, 32'h0000_803C);
    wr(8'h04, 32'h0000_1234, 4'hF, r);
    chk({30'h0, r}, 32'h0);
    rd(8'h04, d, r);
    chk(d, 32'h0000_0180);
    wr(8'h08, 32'h0000_8000, 4'h2, r);
    chk({31'h0, register_write_lockout}, 32'h1);
    rd(8'h08, d, r);
    chk(d, 32'h0000_800F);
    wr(8'h08, 32'h0, 4'h1, r);
    chk({31'h0, register_write_lockout}, 32'h1);
    wr(8'h08, 32'h0, 4'h2, r);
    chk({31'h0, register_write_lockout}, 32'h0);
    // Unmapped and unaligned places
    foreach (bad[k]) begin
      rd(bad[k], d, r);
      chk({d[29:0], r}, 32'h3);
      wr(bad[k], 32'hFFFF_FFFF, 4'hF, r);
      chk({30'h0, r}, 32'h3);
    end
    chk({31'h0, register_write_lockout}, 32'h0);
    // Clock enable low freezes the mirrors
    ce <= 1'b0;
    major_phase <= 3'h2;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    rd(8'h08, d, r);
    chk(d, 32'h0000_000F);
    rd(8'h08, d, r);
    chk(d, 32'h0000_000A);
    end_sim();
  end
endmodule
`default_nettype wire
